// ### design/aacp_pkg.sv
// package for the audio adc clock, peak and strap control block
// assumes one 125 MHz core clock and synchronous active-high reset
package aacp_pkg;

  // ***********************************
  // register addresses (4-bit)
  // ***********************************
  localparam logic [3:0] LEFT_PEAK_ADDR = 4'h3;
  localparam logic [3:0] RIGHT_PEAK_ADDR = 4'h4;
  localparam logic [3:0] CTRL3_ADDR = 4'h2;

  // ***********************************
  // readback word layout
  // ***********************************
  localparam int ADDR_LSB = 12;
  localparam int MARK_ONE_BIT = 11;
  localparam int MARK_ZERO_BIT = 10;
  localparam int PEAK_W = 6;
  localparam logic [5:0] PEAK_FULL_SCALE = 6'h00;
  localparam logic [5:0] PEAK_FLOOR = 6'h3F;

  // ***********************************
  // control register three fields
  // ***********************************
  localparam int DIV_LSB = 6;
  localparam int LEFT_MUX_DIS_BIT = 3;
  localparam int RIGHT_MUX_DIS_BIT = 1;

  // ***********************************
  // encodings
  // ***********************************
  typedef enum logic [1:0] {
    AACP_DIV1 = 2'h0,
    AACP_DIV2 = 2'h1,
    AACP_DIV3 = 2'h2,
    AACP_DIV1B = 2'h3
  } aacp_div_e;

  typedef enum logic [1:0] {
    AACP_FMT_I2S = 2'h0,
    AACP_FMT_RJ = 2'h1,
    AACP_FMT_DSP = 2'h2,
    AACP_FMT_LJ = 2'h3
  } aacp_fmt_e;

  typedef enum logic [1:0] {
    AACP_RATIO_256 = 2'h0,
    AACP_RATIO_512 = 2'h1
  } aacp_ratio_e;

  // power-on defaults
  localparam logic DEF_SLAVE = 1'b0;
  localparam logic [1:0] DEF_RATIO = 2'h0;
  localparam logic [1:0] DEF_FMT = 2'h0;
  localparam logic [1:0] DEF_DIV = 2'h0;

  // modulator clock: one output phase per master-clock edge pair
  localparam int MOD_HALF_CYCLES = 1;

  typedef struct packed {
    logic slave;
    logic [1:0] clock_ratio_field;
    aacp_fmt_e format_select_field;
  } aacp_port_cfg_s;

  typedef struct packed {
    logic [3:0] left;
    logic [3:0] right;
  } aacp_mod_data_s;

endpackage : aacp_pkg

// ### design/aacp_top.sv
// control logic of a stereo audio adc: clock divider, peak registers,
// strap-pin control and modulator bypass output.
// assumes the register interface decode and conversion levels arrive
// on core_clk_in; strap pins are asynchronous and are synchronised here.
//
// What this block does
// R01: divider field 00 and 11 pass clock, 01 halves, 10 thirds it.
// R02: host picks divider so internal clock is 256 times sample rate.
// R03: two read-only peak registers at addresses 0011b and 0100b.
// R04: readback has address on top, bit 11 one, bit 10 zero, 9-6 zero.
// R05: peaks tracked and held only while peak enable is set.
// R06: peak value sits in six low bits of sixteen-bit readback.
// R07: peak code is binary, one dB per count, zero is full scale.
// R08: reading a peak register zeroes it, then updates resume.
// R09: external control strap high takes mode settings from pins.
// R10: master/slave pin low makes device master, driving frame and bit clocks.
// R11: master/slave pin high makes device slave; clocks become inputs.
// R12: ratio pin low selects 256x master clock, high selects 512x.
// R13: two format pins act exactly like the format register field.
// R14: format 00 i2s, 01 right-justified, 10 dsp, 11 left-justified.
// R15: in external control other functions stay at power-on defaults; the mux disable bits still drive direct_input_out here.
// R16: modulator mode bypasses decimation, raw data on four pins.
// R17: modulator mode drives data pins and control-out pin as 128x clock.
// R18: left data during modulator clock low, right data during high.
// R19: host sets both mux disable bits for direct modulator input.
// R20: held code takes the first sample after reset or read, then updates only on louder level; saturates at 63 dB code.
`timescale 1ns/1ps
module aacp_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // register control (from serial control port decode)
  input wire logic peak_enable_in,
  input wire logic modulator_mode_enable_in,
  input wire logic [1:0] clock_divider_field_in,
  input wire logic reg_slave_in,
  input wire logic [1:0] reg_clock_ratio_field_in,
  input wire logic [1:0] reg_format_select_field_in,
  input wire logic left_mux_disable_in,
  input wire logic right_mux_disable_in,
  input wire logic rd_strobe_in,
  input wire logic [3:0] rd_addr_in,
  // conversion levels, attenuation code per sample
  input wire logic sample_valid_in,
  input wire logic [5:0] left_level_in,
  input wire logic [5:0] right_level_in,
  // raw modulator words
  input wire aacp_pkg::aacp_mod_data_s mod_data_in,
  // strap pins (asynchronous)
  input wire logic external_control_strap_in,
  input wire logic master_slave_strap_in,
  input wire logic ratio_strap_in,
  input wire logic [1:0] format_strap_in,
  // internal clock enable and mode outputs
  output logic internal_master_clock_out,
  output aacp_pkg::aacp_port_cfg_s port_cfg_out,
  output logic [1:0] eff_divider_out,
  output logic frame_clocks_oe_out,
  // readback
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  // modulator outputs
  output logic [3:0] modulator_data_out,
  output logic modulator_data_oe_out,
  output logic control_data_out_pin_out,
  output logic direct_input_out
);

  // ***********************************
  // strap synchronisers
  // ***********************************
  localparam int STRAP_W = 5;
  logic [STRAP_W-1:0] strap_meta_r;
  logic [STRAP_W-1:0] strap_sync_r;
  logic [STRAP_W-1:0] strap_raw;

  assign strap_raw = {external_control_strap_in, master_slave_strap_in,
                      ratio_strap_in, format_strap_in};

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      strap_meta_r <= '0;
      strap_sync_r <= '0;
    end else begin
      strap_meta_r <= strap_raw;
      strap_sync_r <= strap_meta_r;
    end
  end

  logic ext_ctrl;
  assign ext_ctrl = strap_sync_r[4]; // R09

  // ***********************************
  // mode selection
  // ***********************************
  aacp_pkg::aacp_port_cfg_s cfg_nxt;
  logic [1:0] div_sel;
  logic peak_en;
  logic mod_en;

  always_comb begin
    if (ext_ctrl) begin
      cfg_nxt.slave = strap_sync_r[3]; // R10 R11
      cfg_nxt.clock_ratio_field = strap_sync_r[2] ? aacp_pkg::AACP_RATIO_512
                                                  : aacp_pkg::AACP_RATIO_256; // R12
      cfg_nxt.format_select_field = aacp_pkg::aacp_fmt_e'(strap_sync_r[1:0]); // R13 R14
      div_sel = aacp_pkg::DEF_DIV; // R15
      peak_en = 1'b0; // R15
      mod_en = 1'b0; // R15
    end else begin
      cfg_nxt.slave = reg_slave_in;
      cfg_nxt.clock_ratio_field = reg_clock_ratio_field_in;
      cfg_nxt.format_select_field = aacp_pkg::aacp_fmt_e'(reg_format_select_field_in); // R14
      div_sel = clock_divider_field_in;
      peak_en = peak_enable_in;
      mod_en = modulator_mode_enable_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      port_cfg_out <= '{slave: aacp_pkg::DEF_SLAVE,
                        clock_ratio_field: aacp_pkg::DEF_RATIO,
                        format_select_field: aacp_pkg::AACP_FMT_I2S};
      eff_divider_out <= aacp_pkg::DEF_DIV;
      frame_clocks_oe_out <= 1'b1;
    end else begin
      port_cfg_out <= cfg_nxt;
      eff_divider_out <= div_sel;
      frame_clocks_oe_out <= ~cfg_nxt.slave; // R10 R11
    end
  end

  // ***********************************
  // master clock divider
  // ***********************************
  // internal clock leaves as a one-cycle enable, not a derived clock
  function automatic logic [1:0] div_terminal(input logic [1:0] code);
    case (code)
      aacp_pkg::AACP_DIV2: div_terminal = 2'h1;
      aacp_pkg::AACP_DIV3: div_terminal = 2'h2;
      default: div_terminal = 2'h0; // R01
    endcase
  endfunction : div_terminal

  logic [1:0] div_cnt_r;
  logic [1:0] div_cnt_nxt;
  logic div_tick;

  assign div_tick = (div_cnt_r >= div_terminal(div_sel)); // R01
  assign div_cnt_nxt = div_tick ? 2'h0 : 2'(div_cnt_r + 2'h1);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      div_cnt_r <= 2'h0;
      internal_master_clock_out <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      internal_master_clock_out <= div_tick;
    end
  end

  // ***********************************
  // peak tracking
  // ***********************************
  // a code of zero after a read means full scale; next sample overwrites
  logic [5:0] peak_r [2];
  logic [1:0] seen_r;
  logic [5:0] level [2];
  logic [1:0] rd_hit;

  assign level[0] = left_level_in;
  assign level[1] = right_level_in;
  assign rd_hit[0] = rd_strobe_in && (rd_addr_in == aacp_pkg::LEFT_PEAK_ADDR);
  assign rd_hit[1] = rd_strobe_in && (rd_addr_in == aacp_pkg::RIGHT_PEAK_ADDR);

  for (genvar ch = 0; ch < 2; ch++) begin : g_peak
    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        peak_r[ch] <= aacp_pkg::PEAK_FULL_SCALE;
        seen_r[ch] <= 1'b0;
      end else if (rd_hit[ch]) begin
        peak_r[ch] <= aacp_pkg::PEAK_FULL_SCALE; // R08
        seen_r[ch] <= 1'b0; // R08
      end else if (peak_en && sample_valid_in) begin // R05
        // smaller code is louder; floor code is the saturation point
        if (!seen_r[ch] || level[ch] < peak_r[ch]) begin
          peak_r[ch] <= level[ch]; // R20 R07
        end
        seen_r[ch] <= 1'b1;
      end
    end
  end

  // ***********************************
  // readback
  // ***********************************
  function automatic logic [15:0] peak_word(input logic [3:0] addr, input logic [5:0] code);
    logic [15:0] w;
    w = '0; // R04
    w[aacp_pkg::ADDR_LSB +: 4] = addr; // R04
    w[aacp_pkg::MARK_ONE_BIT] = 1'b1; // R04
    w[aacp_pkg::MARK_ZERO_BIT] = 1'b0; // R04
    w[aacp_pkg::PEAK_W-1:0] = code; // R06
    peak_word = w;
  endfunction : peak_word

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= |rd_hit; // R03
      if (rd_hit[0]) begin
        rd_data_out <= peak_word(aacp_pkg::LEFT_PEAK_ADDR, peak_r[0]); // R03
      end else if (rd_hit[1]) begin
        rd_data_out <= peak_word(aacp_pkg::RIGHT_PEAK_ADDR, peak_r[1]); // R03
      end
    end
  end

  // ***********************************
  // modulator mode
  // ***********************************
  // clock toggles every core cycle; rate set by the upstream timing
  logic mod_clk_r;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mod_clk_r <= 1'b0;
      modulator_data_out <= 4'h0;
      modulator_data_oe_out <= 1'b0;
      control_data_out_pin_out <= 1'b0;
      direct_input_out <= 1'b0;
    end else begin
      modulator_data_oe_out <= mod_en; // R16 R17
      direct_input_out <= left_mux_disable_in & right_mux_disable_in; // R19
      if (mod_en) begin
        mod_clk_r <= ~mod_clk_r; // R17
        control_data_out_pin_out <= ~mod_clk_r; // R17
        // data changes with the clock so each phase holds its channel
        modulator_data_out <= mod_clk_r ? mod_data_in.left
                                        : mod_data_in.right; // R18
      end else begin
        mod_clk_r <= 1'b0;
        control_data_out_pin_out <= 1'b0;
        modulator_data_out <= 4'h0;
      end
    end
  end

endmodule : aacp_top

// ### tb/aacp_chk.sv
// checker for aacp_top: readback, divider, strap and modulator relations
// assumes binding to aacp_top, one core clock, sync reset
`timescale 1ns/1ps
module aacp_chk (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // watched inputs
  input wire logic rd_strobe_in,
  input wire logic [3:0] rd_addr_in,
  input wire logic modulator_mode_enable_in,
  input wire logic left_mux_disable_in,
  input wire logic right_mux_disable_in,
  input wire logic external_control_strap_in,
  input wire logic master_slave_strap_in,
  input wire logic ratio_strap_in,
  input wire logic [1:0] format_strap_in,
  // watched outputs
  input wire logic internal_master_clock_out,
  input wire aacp_pkg::aacp_port_cfg_s port_cfg_out,
  input wire logic [1:0] eff_divider_out,
  input wire logic frame_clocks_oe_out,
  input wire logic [15:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic modulator_data_oe_out,
  input wire logic control_data_out_pin_out,
  input wire logic direct_input_out
);
  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_good_rd;
    rd_strobe_in && rd_addr_in inside {4'h3, 4'h4};
  endsequence
  sequence s_div2;
    eff_divider_out == 2'h1 && internal_master_clock_out ##1 eff_divider_out == 2'h1 [*2];
  endsequence
  sequence s_div3;
    eff_divider_out == 2'h2 && internal_master_clock_out ##1 eff_divider_out == 2'h2 [*3];
  endsequence
  // strap pins need three edges to settle through the synchroniser
  sequence s_strap;
    (external_control_strap_in
      && $stable({master_slave_strap_in, ratio_strap_in, format_strap_in})) [*4];
  endsequence
  a_rd_word: assert property (s_good_rd |=> rd_valid_out && rd_data_out[15:6]
    == {$past(rd_addr_in), 6'h20}) else $error("bad readback word");
  a_rd_none: assert property (!(rd_strobe_in && rd_addr_in inside {4'h3, 4'h4}) |=> !rd_valid_out)
    else $error("readback without a valid read");
  a_div_one: assert property ((eff_divider_out inside {2'h0, 2'h3}) [*3]
    |-> internal_master_clock_out) else $error("divide by one missed tick");
  a_div_two: assert property (s_div2 |-> !$past(internal_master_clock_out)
    && internal_master_clock_out) else $error("divide by two spacing");
  a_div_three: assert property (s_div3 |-> !$past(internal_master_clock_out, 2)
    && !$past(internal_master_clock_out) && internal_master_clock_out)
    else $error("divide by three spacing");
  a_strap_cfg: assert property (s_strap |-> port_cfg_out
    == {master_slave_strap_in, 1'b0, ratio_strap_in, format_strap_in})
    else $error("strap config wrong");
  a_strap_clk: assert property (s_strap |-> frame_clocks_oe_out == !master_slave_strap_in)
    else $error("frame clock direction wrong");
  a_strap_dflt: assert property (s_strap |-> eff_divider_out == 2'h0 && !modulator_data_oe_out)
    else $error("strap mode not at defaults");
  a_mod_on: assert property ((modulator_mode_enable_in && !external_control_strap_in) [*4]
    |-> modulator_data_oe_out) else $error("modulator pins not driven");
  a_mod_toggle: assert property (modulator_data_oe_out && $past(modulator_data_oe_out)
    |-> control_data_out_pin_out != $past(control_data_out_pin_out))
    else $error("modulator clock stuck");
  a_mod_idle: assert property (!modulator_data_oe_out && !$past(modulator_data_oe_out)
    |-> !control_data_out_pin_out) else $error("control out busy when idle");
  a_direct_in: assert property (left_mux_disable_in && right_mux_disable_in
    |=> direct_input_out) else $error("direct input not flagged");
endmodule : aacp_chk

bind aacp_top aacp_chk chk (.*);

// ### tb/aacp_host.sv
// host side model: samples modulator words per clock phase, drives frame clock
// assumes the same core clock as the device
`timescale 1ns/1ps
module aacp_host (
  // clock
  input wire logic clk_in,
  // device pins
  input wire logic mod_clk_in,
  input wire logic [3:0] mod_data_in,
  input wire logic mod_oe_in,
  input wire logic frame_oe_in,
  // captures and frame clock
  output logic [3:0] left_seen_out,
  output logic [3:0] right_seen_out,
  output logic frame_clk_out
);
  always_ff @(posedge clk_in) begin
    if (mod_oe_in && !mod_clk_in) left_seen_out <= mod_data_in;
    if (mod_oe_in && mod_clk_in) right_seen_out <= mod_data_in;
  end
  // stands still while the device is master
  always_ff @(posedge clk_in) frame_clk_out <= !frame_oe_in && !frame_clk_out;
endmodule : aacp_host

// ### tb/audio_adc_clock_peak_control_tb.sv
// self-checking bench for aacp_top with a peak model and the host model
// assumes 125 MHz core clock and sync active-high reset
`timescale 1ns/1ps
module audio_adc_clock_peak_control_tb;
  logic core_clk_in = 1'b0, rst_in = 1'b1, peak_enable_in = 1'b0;
  logic modulator_mode_enable_in = 1'b0, reg_slave_in = 1'b0, rd_strobe_in = 1'b0;
  logic left_mux_disable_in = 1'b0, right_mux_disable_in = 1'b0, sample_valid_in = 1'b0;
  logic external_control_strap_in = 1'b0, master_slave_strap_in = 1'b0, ratio_strap_in = 1'b0;
  logic [1:0] clock_divider_field_in = 2'h0, reg_clock_ratio_field_in = 2'h0;
  logic [1:0] reg_format_select_field_in = 2'h0, format_strap_in = 2'h0, eff_divider_out;
  logic [3:0] rd_addr_in = 4'h0, modulator_data_out, ls, rs;
  logic [5:0] left_level_in = 6'h00, right_level_in = 6'h00;
  aacp_pkg::aacp_mod_data_s mod_data_in = 8'h00;
  aacp_pkg::aacp_port_cfg_s port_cfg_out;
  logic [15:0] rd_data_out, seed = 16'hAA4D;
  logic internal_master_clock_out, frame_clocks_oe_out, rd_valid_out, modulator_data_oe_out;
  logic control_data_out_pin_out, direct_input_out, fclk;
  int pk [2] = '{0, 0};
  bit fresh [2] = '{1, 1};
  int miscompares = 0, n_compared = 0, n;
  aacp_top dut (.*);
  aacp_host host (.clk_in(core_clk_in), .mod_clk_in(control_data_out_pin_out),
    .mod_data_in(modulator_data_out), .mod_oe_in(modulator_data_oe_out),
    .frame_oe_in(frame_clocks_oe_out), .left_seen_out(ls), .right_seen_out(rs),
    .frame_clk_out(fclk));
  always #4 core_clk_in = !core_clk_in;
  // ***********************************
  // tasks
  // ***********************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task step;
    @(posedge core_clk_in);
    #1;
  endtask : step
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // read and sample may share an edge; the read channel drops that sample
  task op(input logic r, input logic [3:0] a, input logic s);
    int ch;
    logic [15:0] ew;
    ch = int'(a) - 3;
    ew = 16'h0000;
    if (r && ch inside {0, 1}) ew = {a, 6'h20, pk[ch][5:0]};
    rd_strobe_in = r;
    rd_addr_in = a;
    sample_valid_in = s;
    peak_enable_in = seed[6];
    left_level_in = seed[5:0];
    right_level_in = seed[13:8];
    for (int c = 0; c < 2; c++) if (s && peak_enable_in && !(r && ch == c)) begin
      n = c ? right_level_in : left_level_in;
      if (fresh[c] || n < pk[c]) pk[c] = n;
      fresh[c] = 0;
    end
    seed = lfsr(seed);
    step;
    if (r && ch inside {0, 1}) begin
      chk(rd_data_out, ew);
      chk(rd_valid_out, 1'b1);
      pk[ch] = 0;
      fresh[ch] = 1;
    end else chk(rd_valid_out, 1'b0);
  endtask : op
  task results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    #100000;
    miscompares++;
    results;
  end
  // ***********************************
  // tests
  // ***********************************
  initial begin
    repeat (8) step;
    rst_in = 1'b0;
    peak_enable_in = 1'b1;
    repeat (3) step;
    for (int i = 0; i < 80; i++) op(seed[0], {2'h0, seed[2:1]} + 4'h2, seed[4]);
    // strobes stay up between back-to-back ops, dropped once here
    rd_strobe_in = 1'b0;
    sample_valid_in = 1'b0;
    $display("peak test done");
    for (int d = 0; d < 4; d++) begin
      clock_divider_field_in = d[1:0];
      repeat (6) step;
      chk(eff_divider_out, d[1:0]);
      n = 0;
      repeat (12) begin
        step;
        n += internal_master_clock_out;
      end
      chk(n, d == 1 ? 6 : d == 2 ? 4 : 12);
    end
    $display("divider test done");
    {modulator_mode_enable_in, left_mux_disable_in, right_mux_disable_in} = 3'h7;
    for (int i = 0; i < 3; i++) begin
      mod_data_in = seed[7:0];
      seed = lfsr(seed);
      repeat (8) step;
      chk({ls, rs}, mod_data_in);
      chk({modulator_data_oe_out, direct_input_out}, 2'h3);
    end
    modulator_mode_enable_in = 1'b0;
    $display("modulator test done");
    external_control_strap_in = 1'b1;
    clock_divider_field_in = 2'h1;
    for (int i = 0; i < 16; i++) begin
      {master_slave_strap_in, ratio_strap_in, format_strap_in} = i[3:0];
      repeat (6) step;
      chk(port_cfg_out, {i[3], 1'b0, i[2:0]});
      chk({frame_clocks_oe_out, eff_divider_out}, {!i[3], 2'h0});
    end
    external_control_strap_in = 1'b0;
    {reg_slave_in, reg_clock_ratio_field_in, reg_format_select_field_in} = 5'h17;
    repeat (6) step;
    chk({frame_clocks_oe_out, port_cfg_out}, 6'h17);
    $display("strap test done");
    results;
  end
endmodule : audio_adc_clock_peak_control_tb
